// File: sdl_strap_default_loader.sv
// Summary of operation
// - The LED mode select default follows its strap: low gives eight GPIOs, high eight LEDs.
// - Each bit of the two-bit LED function field defaults from its own strap pin.
// - Port 1 automatic crossover defaults enabled on a high strap and disabled on a low.
// - Port 1 auto-negotiation enable defaults from its strap.
// - Port 1 speed select low bit defaults from its strap, low 10 Mbps and high 100 Mbps.
// - Port 1 duplex mode defaults from its strap, low half and high full duplex.
// - Port 1 backpressure enable defaults from its strap.
// - One strap loads both port 1 transmit and receive pause enables.
// - Port 1 manual flow select defaults from its strap, low follows auto-negotiation.
// - Port 2 automatic crossover defaults from its strap.
// - Port 2 auto-negotiation enable defaults from its strap.
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"
module sdl_strap_default_loader
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// strap pins
	input wire logic i_led_mode_select,
	input wire logic [1:0] i_led_function_field,
	input wire logic i_port1_crossover_strap,
	input wire logic i_port1_autoneg_strap,
	input wire logic i_port1_speed_strap,
	input wire logic i_port1_duplex_strap,
	input wire logic i_port1_backpressure_strap,
	input wire logic i_port1_fullduplex_flow_strap,
	input wire logic i_port1_manual_flow_strap,
	input wire logic i_port2_crossover_strap,
	input wire logic i_port2_autoneg_strap,
	// led configuration register defaults
	output logic o_led_mode_select,
	output logic [1:0] o_led_function_field,
	// port 1 phy basic control defaults
	output logic o_port1_crossover_enable,
	output logic o_port1_autoneg_enable_bit,
	output logic o_port1_speed_select_low_bit,
	output logic o_port1_duplex_mode_bit,
	// port 1 manual flow register defaults
	output logic o_port1_backpressure_enable,
	output logic o_port1_tx_pause_enable,
	output logic o_port1_rx_pause_enable,
	output logic o_port1_manual_flow_select,
	// port 2 phy basic control defaults
	output logic o_port2_crossover_enable,
	output logic o_port2_autoneg_enable_bit,
	// defaults valid
	output logic o_defaults_loaded
);
	logic [`SDL_STRAP_W-1:0] pins;
	logic [`SDL_STRAP_W-1:0] synced;
	logic [`SDL_STRAP_W-1:0] latched;
	logic capture;
	logic loaded;
	logic [`SDL_STRAP_W-1:0] outs;
	logic [`SDL_STRAP_W-1:0] first_outs;
	logic held;
	logic cap_seen;

	// ---------------------------------------------------------------
	// strap pins in
	// ---------------------------------------------------------------
	// gather pins into one vector
	assign pins[`SDL_B_LED_MODE] = i_led_mode_select;
	assign pins[`SDL_B_LED_FUN0] = i_led_function_field[0];
	assign pins[`SDL_B_LED_FUN1] = i_led_function_field[1];
	assign pins[`SDL_B_P1_XOVER] = i_port1_crossover_strap;
	assign pins[`SDL_B_P1_AN] = i_port1_autoneg_strap;
	assign pins[`SDL_B_P1_SPEED] = i_port1_speed_strap;
	assign pins[`SDL_B_P1_DUPLEX] = i_port1_duplex_strap;
	assign pins[`SDL_B_P1_BP] = i_port1_backpressure_strap;
	assign pins[`SDL_B_P1_FDFC] = i_port1_fullduplex_flow_strap;
	assign pins[`SDL_B_P1_MANFC] = i_port1_manual_flow_strap;
	assign pins[`SDL_B_P2_XOVER] = i_port2_crossover_strap;
	assign pins[`SDL_B_P2_AN] = i_port2_autoneg_strap;

	// ---------------------------------------------------------------
	// synchroniser and capture
	// ---------------------------------------------------------------
	// pin synchroniser, stable straps assumed during sampling
	sdl_sync u_sync
	(
		.i_mclk(i_mclk),
		.i_arst_n(i_arst_n),
		.i_pin(pins),
		.o_sync(synced)
	);

	// one-shot capture sequencer
	sdl_seq u_seq
	(
		.i_mclk(i_mclk),
		.i_arst_n(i_arst_n),
		.o_capture(capture),
		.o_loaded(loaded)
	);

	// latch straps once after release, hold afterwards
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			latched <= `SDL_STRAP_RST;
		else if (capture && !loaded)
			latched <= synced;
	end

	// ---------------------------------------------------------------
	// default outputs
	// ---------------------------------------------------------------
	// led configuration defaults
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_led_mode_select <= 1'b1;
			o_led_function_field <= 2'h3;
		end
		else
		begin
			o_led_mode_select <= latched[`SDL_B_LED_MODE];
			o_led_function_field[0] <= latched[`SDL_B_LED_FUN0];
			o_led_function_field[1] <= latched[`SDL_B_LED_FUN1];
		end
	end

	// port 1 phy control defaults
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_port1_crossover_enable <= 1'b1;
			o_port1_autoneg_enable_bit <= 1'b1;
			o_port1_speed_select_low_bit <= 1'b1;
			o_port1_duplex_mode_bit <= 1'b1;
		end
		else
		begin
			o_port1_crossover_enable <= latched[`SDL_B_P1_XOVER];
			o_port1_autoneg_enable_bit <= latched[`SDL_B_P1_AN];
			o_port1_speed_select_low_bit <= latched[`SDL_B_P1_SPEED];
			o_port1_duplex_mode_bit <= latched[`SDL_B_P1_DUPLEX];
		end
	end

	// port 1 flow control defaults
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_port1_backpressure_enable <= 1'b1;
			o_port1_tx_pause_enable <= 1'b1;
			o_port1_rx_pause_enable <= 1'b1;
			o_port1_manual_flow_select <= 1'b1;
		end
		else
		begin
			o_port1_backpressure_enable <= latched[`SDL_B_P1_BP];
			o_port1_tx_pause_enable <= latched[`SDL_B_P1_FDFC];
			o_port1_rx_pause_enable <= latched[`SDL_B_P1_FDFC];
			o_port1_manual_flow_select <= latched[`SDL_B_P1_MANFC];
		end
	end

	// port 2 defaults and load flag
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_port2_crossover_enable <= 1'b1;
			o_port2_autoneg_enable_bit <= 1'b1;
			o_defaults_loaded <= 1'b0;
		end
		else
		begin
			o_port2_crossover_enable <= latched[`SDL_B_P2_XOVER];
			o_port2_autoneg_enable_bit <= latched[`SDL_B_P2_AN];
			o_defaults_loaded <= loaded;
		end
	end

	// ---------------------------------------------------------------
	// check helpers
	// ---------------------------------------------------------------
	// outputs gathered in strap order for the checks below
	assign outs[`SDL_B_LED_MODE] = o_led_mode_select;
	assign outs[`SDL_B_LED_FUN0] = o_led_function_field[0];
	assign outs[`SDL_B_LED_FUN1] = o_led_function_field[1];
	assign outs[`SDL_B_P1_XOVER] = o_port1_crossover_enable;
	assign outs[`SDL_B_P1_AN] = o_port1_autoneg_enable_bit;
	assign outs[`SDL_B_P1_SPEED] = o_port1_speed_select_low_bit;
	assign outs[`SDL_B_P1_DUPLEX] = o_port1_duplex_mode_bit;
	assign outs[`SDL_B_P1_BP] = o_port1_backpressure_enable;
	assign outs[`SDL_B_P1_FDFC] = o_port1_tx_pause_enable;
	assign outs[`SDL_B_P1_MANFC] = o_port1_manual_flow_select;
	assign outs[`SDL_B_P2_XOVER] = o_port2_crossover_enable;
	assign outs[`SDL_B_P2_AN] = o_port2_autoneg_enable_bit;

	// outputs as first shown after loading, kept for the long hold check
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			held <= 1'b0;
			first_outs <= `SDL_STRAP_RST;
		end
		else
		begin
			held <= o_defaults_loaded;
			if (!held)
				first_outs <= outs;
		end
	end

	// remembers that the one capture of this reset has happened
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			cap_seen <= 1'b0;
		else if (capture)
			cap_seen <= 1'b1;
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	AST_LED_MODE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_defaults_loaded |-> o_led_mode_select == latched[`SDL_B_LED_MODE])
		else $error("led mode default wrong");
	AST_LED_FUNCTION_FIELD: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_defaults_loaded |-> o_led_function_field == {latched[`SDL_B_LED_FUN1],
			latched[`SDL_B_LED_FUN0]})
		else $error("led function default wrong");
	AST_P1_XOVER: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_defaults_loaded |-> o_port1_crossover_enable == latched[`SDL_B_P1_XOVER])
		else $error("port1 crossover default wrong");
	AST_P1_AN: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_defaults_loaded |-> o_port1_autoneg_enable_bit == latched[`SDL_B_P1_AN])
		else $error("port1 autoneg default wrong");
	AST_P1_SPEED: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_defaults_loaded |-> o_port1_speed_select_low_bit == latched[`SDL_B_P1_SPEED])
		else $error("port1 speed default wrong");
	AST_P1_DUPLEX: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_defaults_loaded |-> o_port1_duplex_mode_bit == latched[`SDL_B_P1_DUPLEX])
		else $error("port1 duplex default wrong");
	AST_P1_BP: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_defaults_loaded |-> o_port1_backpressure_enable == latched[`SDL_B_P1_BP])
		else $error("port1 backpressure default wrong");
	AST_P1_PAUSE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_port1_tx_pause_enable == o_port1_rx_pause_enable)
		else $error("port1 pause enables differ");
	AST_P1_MANFC: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_defaults_loaded |-> o_port1_manual_flow_select == latched[`SDL_B_P1_MANFC])
		else $error("port1 manual flow default wrong");
	AST_P2_XOVER: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_defaults_loaded |-> o_port2_crossover_enable == latched[`SDL_B_P2_XOVER])
		else $error("port2 crossover default wrong");
	AST_P2_AN: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_defaults_loaded |-> o_port2_autoneg_enable_bit == latched[`SDL_B_P2_AN])
		else $error("port2 autoneg default wrong");
	AST_HOLD: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		loaded && $past(loaded) |-> $stable(latched))
		else $error("straps changed after capture");
	AST_ONCE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		capture |=> !capture [*4])
		else $error("second capture strobe");

	// ---------------------------------------------------------------
	// port 1 pause default and capture sequence checks
	// ---------------------------------------------------------------
	AST_P1_TX: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_defaults_loaded |-> o_port1_tx_pause_enable == latched[`SDL_B_P1_FDFC])
		else $error("port1 tx pause default wrong");
	AST_P1_RX: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_defaults_loaded |-> o_port1_rx_pause_enable == latched[`SDL_B_P1_FDFC])
		else $error("port1 rx pause default wrong");
	AST_PRE_LOAD: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		!o_defaults_loaded |-> outs == `SDL_STRAP_RST &&
			o_port1_rx_pause_enable)
		else $error("defaults shown before capture");
	AST_CAPTURE_VALUE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		capture && !loaded |=> latched == $past(synced))
		else $error("capture did not take synchronised straps");
	AST_CAPTURE_FIRST: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		capture |-> !loaded && !o_defaults_loaded)
		else $error("capture after defaults loaded");
	AST_LOAD_TIME: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		$rose(capture) |-> !o_defaults_loaded ##1 !o_defaults_loaded
			##1 o_defaults_loaded)
		else $error("defaults loaded flag mistimed");
	AST_LOADED_STAYS: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_defaults_loaded |=> o_defaults_loaded)
		else $error("defaults loaded flag dropped");
	AST_OUT_STABLE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		o_defaults_loaded && $past(o_defaults_loaded) |-> $stable(outs) &&
			$stable(o_port1_rx_pause_enable))
		else $error("defaults moved after loading");
	AST_LONG_HOLD: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		held |-> outs == first_outs)
		else $error("defaults differ from first loaded value");
	AST_ONE_CAPTURE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		capture |-> !cap_seen)
		else $error("more than one capture in one reset");
endmodule
`default_nettype wire

// File: sdl_map.svh
`ifndef SDL_MAP_SVH
`define SDL_MAP_SVH
// strap vector bit positions
`define SDL_STRAP_W 12
`define SDL_B_LED_MODE 0
`define SDL_B_LED_FUN0 1
`define SDL_B_LED_FUN1 2
`define SDL_B_P1_XOVER 3
`define SDL_B_P1_AN 4
`define SDL_B_P1_SPEED 5
`define SDL_B_P1_DUPLEX 6
`define SDL_B_P1_BP 7
`define SDL_B_P1_FDFC 8
`define SDL_B_P1_MANFC 9
`define SDL_B_P2_XOVER 10
`define SDL_B_P2_AN 11
// reset value of captured straps: the pins carry pull-ups
`define SDL_STRAP_RST 12'hFFF
// cycles after reset release before the sample is taken
`define SDL_SETTLE_CYC 4'h8
`define SDL_CNT_W 4
`endif

// File: sdl_pkg.sv
`default_nettype none
package sdl_pkg;
	// loader sequencing states
	typedef enum logic [2:0] {
		SDL_WAIT = 3'h1,
		SDL_SAMPLE = 3'h2,
		SDL_HOLD = 3'h4
	} sdl_state_t;
endpackage
`default_nettype wire

// File: sdl_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"
module sdl_sync
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// pins in, synchronised out
	input wire logic [`SDL_STRAP_W-1:0] i_pin,
	output logic [`SDL_STRAP_W-1:0] o_sync
);
	logic [`SDL_STRAP_W-1:0] meta;

	// two flip-flops per strap bit
	genvar g;
	generate
		for (g = 0; g < `SDL_STRAP_W; g = g + 1)
		begin : g_bit
			always_ff @(posedge i_mclk or negedge i_arst_n)
			begin
				if (!i_arst_n)
				begin
					meta[g] <= 1'b1;
					o_sync[g] <= 1'b1;
				end
				else
				begin
					meta[g] <= i_pin[g];
					o_sync[g] <= meta[g];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// File: sdl_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"
module sdl_seq
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// one-cycle capture strobe and done level
	output logic o_capture,
	output logic o_loaded
);
	sdl_pkg::sdl_state_t state;
	logic [`SDL_CNT_W-1:0] cnt;

	// settle counter, lets the synchroniser fill after release
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			cnt <= 4'h0;
		else if (state == sdl_pkg::SDL_WAIT)
			cnt <= cnt + 4'h1;
	end

	// sample exactly once per reset
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			state <= sdl_pkg::SDL_WAIT;
		else
		begin
			case (state)
				sdl_pkg::SDL_WAIT:
					if (cnt == `SDL_SETTLE_CYC - 4'h1)
						state <= sdl_pkg::SDL_SAMPLE;
				sdl_pkg::SDL_SAMPLE:
					state <= sdl_pkg::SDL_HOLD;
				sdl_pkg::SDL_HOLD:
					state <= sdl_pkg::SDL_HOLD;
				default:
					state <= sdl_pkg::SDL_WAIT;
			endcase
		end
	end

	// outputs
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_capture <= 1'b0;
			o_loaded <= 1'b0;
		end
		else
		begin
			o_capture <= (state == sdl_pkg::SDL_WAIT) && (cnt == `SDL_SETTLE_CYC - 4'h1);
			o_loaded <= o_capture | o_loaded;
		end
	end
endmodule
`default_nettype wire

// File: sdl_board.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"
// ----------------------------------------
// board straps behind the loader
// ----------------------------------------
module sdl_board
(
	// wanted levels and fitted resistors
	input wire logic [`SDL_STRAP_W-1:0] i_level,
	input wire logic [`SDL_STRAP_W-1:0] i_fitted,
	// strap pins
	output logic [`SDL_STRAP_W-1:0] o_pin
);
	// a fitted resistor holds its level steady, an open pin rides the pull-up
	assign o_pin = (i_level & i_fitted) | ~i_fitted;
endmodule
`default_nettype wire

// File: sdl_strap_default_loader_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.svh"
module sdl_strap_default_loader_tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int W = `SDL_STRAP_W;
	logic i_mclk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [W-1:0] level = '1;
	logic [W-1:0] fitted = '1;
	logic [W-1:0] exp_v;
	wire [W-1:0] pin;
	wire [W-1:0] o_vec;
	wire rx_pause;
	wire loaded;
	int failures = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [W:0] notes[$];
	event chk;
	// clock
	always #2 i_mclk = ~i_mclk;
	// ----------------------------------------
	// instances
	// ----------------------------------------
	sdl_board u_sdl_board (.i_level(level), .i_fitted(fitted), .o_pin(pin));
	sdl_strap_default_loader u_sdl_strap_default_loader
	(
		.i_mclk(i_mclk),
		.i_arst_n(i_arst_n),
		.i_led_mode_select(pin[`SDL_B_LED_MODE]),
		.i_led_function_field(pin[`SDL_B_LED_FUN1:`SDL_B_LED_FUN0]),
		.i_port1_crossover_strap(pin[`SDL_B_P1_XOVER]),
		.i_port1_autoneg_strap(pin[`SDL_B_P1_AN]),
		.i_port1_speed_strap(pin[`SDL_B_P1_SPEED]),
		.i_port1_duplex_strap(pin[`SDL_B_P1_DUPLEX]),
		.i_port1_backpressure_strap(pin[`SDL_B_P1_BP]),
		.i_port1_fullduplex_flow_strap(pin[`SDL_B_P1_FDFC]),
		.i_port1_manual_flow_strap(pin[`SDL_B_P1_MANFC]),
		.i_port2_crossover_strap(pin[`SDL_B_P2_XOVER]),
		.i_port2_autoneg_strap(pin[`SDL_B_P2_AN]),
		.o_led_mode_select(o_vec[`SDL_B_LED_MODE]),
		.o_led_function_field(o_vec[`SDL_B_LED_FUN1:`SDL_B_LED_FUN0]),
		.o_port1_crossover_enable(o_vec[`SDL_B_P1_XOVER]),
		.o_port1_autoneg_enable_bit(o_vec[`SDL_B_P1_AN]),
		.o_port1_speed_select_low_bit(o_vec[`SDL_B_P1_SPEED]),
		.o_port1_duplex_mode_bit(o_vec[`SDL_B_P1_DUPLEX]),
		.o_port1_backpressure_enable(o_vec[`SDL_B_P1_BP]),
		.o_port1_tx_pause_enable(o_vec[`SDL_B_P1_FDFC]),
		.o_port1_rx_pause_enable(rx_pause),
		.o_port1_manual_flow_select(o_vec[`SDL_B_P1_MANFC]),
		.o_port2_crossover_enable(o_vec[`SDL_B_P2_XOVER]),
		.o_port2_autoneg_enable_bit(o_vec[`SDL_B_P2_AN]),
		.o_defaults_loaded(loaded)
	);
	// ----------------------------------------
	// checking
	// ----------------------------------------
	task automatic check(input logic seen, input logic exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("FAIL %0t seen %b expected %b", $time, seen, exp);
		end
	endtask
	task automatic check_all(input logic [W:0] e);
		check(o_vec[`SDL_B_LED_MODE], e[`SDL_B_LED_MODE]);
		check(o_vec[`SDL_B_LED_FUN0], e[`SDL_B_LED_FUN0]);
		check(o_vec[`SDL_B_LED_FUN1], e[`SDL_B_LED_FUN1]);
		check(o_vec[`SDL_B_P1_XOVER], e[`SDL_B_P1_XOVER]);
		check(o_vec[`SDL_B_P1_AN], e[`SDL_B_P1_AN]);
		check(o_vec[`SDL_B_P1_SPEED], e[`SDL_B_P1_SPEED]);
		check(o_vec[`SDL_B_P1_DUPLEX], e[`SDL_B_P1_DUPLEX]);
		check(o_vec[`SDL_B_P1_BP], e[`SDL_B_P1_BP]);
		check(o_vec[`SDL_B_P1_FDFC], e[`SDL_B_P1_FDFC]);
		check(rx_pause, e[`SDL_B_P1_FDFC]);
		check(o_vec[`SDL_B_P1_MANFC], e[`SDL_B_P1_MANFC]);
		check(o_vec[`SDL_B_P2_XOVER], e[`SDL_B_P2_XOVER]);
		check(o_vec[`SDL_B_P2_AN], e[`SDL_B_P2_AN]);
		check(loaded, e[W]);
	endtask
	// takes the oldest note whenever loading completes or a check is called for
	always
	begin
		@(posedge loaded or chk);
		// look one step later, once every output of that edge has settled
		#1;
		if (notes.size() == 0)
		begin
			failures++;
			$display("FAIL %0t result with no expectation", $time);
		end
		else
			check_all(notes.pop_front());
	end
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	task automatic run_capture(input logic [W-1:0] lv, input logic [W-1:0] ft);
		int n;
		@(posedge i_mclk);
		#1 i_arst_n = 1'b0;
		level = lv;
		fitted = ft;
		repeat (5) @(posedge i_mclk);
		// in reset the outputs sit at the pull-up value, not yet loaded
		#1 notes.push_back({1'b0, {W{1'b1}}});
		-> chk;
		exp_v = (lv & ft) | ~ft;
		notes.push_back({1'b1, exp_v});
		i_arst_n = 1'b1;
		n = 0;
		while (loaded !== 1'b1 && n < 40)
		begin
			@(posedge i_mclk);
			n++;
		end
		if (n == 40)
		begin
			failures++;
			$display("FAIL %0t defaults never loaded", $time);
		end
		// later pin changes must leave the captured defaults alone
		#1 level = ~lv;
		fitted = '1;
		repeat (12) @(posedge i_mclk);
		#1 notes.push_back({1'b1, exp_v});
		-> chk;
		#1 $display("test done straps %h fitted %h", lv, ft);
	endtask
	task automatic give_verdict();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// cut a hang short
	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			failures++;
			$display("FAIL %0t timeout", $time);
			give_verdict();
		end
	end
	// main sequence: all low, all high, then random straps and open pins
	initial
	begin
		void'($urandom(32'h54D3));
		for (int i = 0; i < 8; i++)
		begin
			if (i == 4)
			begin
				// short reset in mid-run, then cut again in mid-settle: no load may show
				@(posedge i_mclk);
				#1 i_arst_n = 1'b0;
				@(posedge i_mclk);
				#1 i_arst_n = 1'b1;
				repeat (3) @(posedge i_mclk);
			end
			if (i == 0)
				run_capture('0, '1);
			else if (i == 1)
				run_capture('1, '1);
			else
				run_capture(W'($urandom()), W'($urandom()));
		end
		give_verdict();
	end
endmodule
`default_nettype wire
